// ### include/xmi_defs.vh
// constants for the mac-side xmii data interface
`ifndef XMI_DEFS_VH
`define XMI_DEFS_VH

// timing, in the units they are specified in
`define XMI_SYS_PERIOD_PS 5000
`define XMI_RGMII_CYC_NS 40
`define XMI_RGMII_CYC_MIN_NS 36
`define XMI_RGMII_CYC_MAX_NS 44
`define XMI_SHIFT_PS 3500
`define XMI_RMII_REF_MHZ 50
// derived cycle counts at the system clock rate
`define XMI_LINK_PERIOD_CYC ((`XMI_RGMII_CYC_NS * 1000) / `XMI_SYS_PERIOD_PS)
`define XMI_RMII_PERIOD_CYC ((1000000 / `XMI_RMII_REF_MHZ) / `XMI_SYS_PERIOD_PS)
`define XMI_SHIFT_CYC ((`XMI_SHIFT_PS + `XMI_SYS_PERIOD_PS - 1) / `XMI_SYS_PERIOD_PS)
`define XMI_STRAP_WAIT_CYC 3'h4

// register byte addresses
`define XMI_REG_CTRL 4'h0
`define XMI_REG_STATUS 4'h4

// control register fields
`define XMI_CTRL_MODE_LO 0
`define XMI_CTRL_MODE_HI 1
`define XMI_CTRL_RX_SHIFT 2
`define XMI_CTRL_TX_SHIFT 3
`define XMI_CTRL_FULL_DUPLEX 4
`define XMI_CTRL_CLKSEL_LO 5
`define XMI_CTRL_CLKSEL_HI 6
`define XMI_CTRL_RMII_MASTER 7
`define XMI_CTRL_RESET 8'h04

// interface modes
`define XMI_MODE_MII 2'h0
`define XMI_MODE_RMII 2'h1
`define XMI_MODE_RGMII 2'h2

// clock output pin selections
`define XMI_CLKSEL_NONE 2'h0
`define XMI_CLKSEL_GP1 2'h1
`define XMI_CLKSEL_GP2 2'h2
`define XMI_CLKSEL_GP3 2'h3

// axi responses
`define XMI_RESP_OKAY 2'h0
`define XMI_RESP_SLVERR 2'h2

`endif

// ### hw/xmi_pin_sync.v
// three-stage pin synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
module xmi_pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // pins in, clean levels out
  input wire [WIDTH-1:0] pin_i,
  output reg [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per bit, so one settling bit does not hold back the others
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_o <= {WIDTH{1'b0}};
    end else begin
      level_o <= (stage3 & agree) | (level_o & ~agree);
    end
  end

endmodule

// ### hw/xmi_mac_if.v
// mac-side xmii data interface of a 10/100 phy: mii, rmii and rgmii with axi4-lite control
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "xmi_defs.vh"
module xmi_mac_if (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // axi4-lite register slave
  input wire [3:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [3:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // straps and reference oscillator
  input wire rmii_master_strap_i,
  input wire osc_in_pin_i,
  // mac transmit pins
  input wire tx_clk_i,
  input wire [3:0] tx_d_i,
  input wire tx_ctrl_i,
  // mac receive and line status pins
  output reg rx_clk_o,
  output wire [3:0] rx_d_o,
  output reg rx_ctrl_o,
  output wire crs_o,
  output wire col_o,
  output wire general_purpose_pin_one_o,
  output wire general_purpose_pin_two_o,
  // line-side byte streams
  input wire [7:0] rx_byte_i,
  input wire rx_byte_err_i,
  input wire rx_byte_valid_i,
  output wire rx_byte_ready_o,
  output reg [7:0] tx_byte_o,
  output reg tx_byte_err_o,
  output reg tx_byte_valid_o,
  output reg tx_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // control register and strap capture

  reg [7:0] ctrl;
  reg [2:0] strap_cnt;
  reg strap_done;
  reg strap_seen;
  wire strap_s;
  wire [1:0] mode = ctrl[`XMI_CTRL_MODE_HI:`XMI_CTRL_MODE_LO];
  wire [1:0] clk_sel = ctrl[`XMI_CTRL_CLKSEL_HI:`XMI_CTRL_CLKSEL_LO];
  wire rx_shift = ctrl[`XMI_CTRL_RX_SHIFT];
  wire tx_shift = ctrl[`XMI_CTRL_TX_SHIFT];
  wire rmii_master = ctrl[`XMI_CTRL_RMII_MASTER];
  wire full_duplex = ctrl[`XMI_CTRL_FULL_DUPLEX];
  wire is_mii = (mode == `XMI_MODE_MII);
  wire is_rmii = (mode == `XMI_MODE_RMII);
  wire is_rgmii = (mode == `XMI_MODE_RGMII);

  reg aw_held;
  reg [3:0] aw_addr_q;
  reg w_held;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid_o;

  xmi_pin_sync #(.WIDTH(1)) u_strap_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pin_i(rmii_master_strap_i),
    .level_o(strap_s)
  );

  // the strap is caught a few cycles after release, once the synchroniser has settled
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= `XMI_CTRL_RESET;
      strap_cnt <= 3'h0;
      strap_done <= 1'b0;
      strap_seen <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 3'h1;
      if (strap_cnt == `XMI_STRAP_WAIT_CYC) begin
        strap_done <= 1'b1;
        strap_seen <= strap_s;
        if (strap_s) begin
          ctrl[`XMI_CTRL_MODE_HI:`XMI_CTRL_MODE_LO] <= `XMI_MODE_RMII;
          ctrl[`XMI_CTRL_RMII_MASTER] <= 1'b1;
          ctrl[`XMI_CTRL_CLKSEL_HI:`XMI_CTRL_CLKSEL_LO] <= `XMI_CLKSEL_GP3;
        end
      end
    end else if (wr_fire && aw_addr_q == `XMI_REG_CTRL && w_strb_q[0]) begin
      ctrl <= w_data_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read in flight, address and data in any order

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `XMI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // status is read-only; writing it is answered as an error
        s_axi_bresp_o <= (aw_addr_q == `XMI_REG_CTRL) ? `XMI_RESP_OKAY : `XMI_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  wire rx_busy;
  wire [31:0] status_word = {27'h0000000, strap_seen, crs_o, col_o, rx_busy, tx_active_o};

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `XMI_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      case (s_axi_araddr_i)
        `XMI_REG_CTRL: begin
          s_axi_rdata_o <= {24'h000000, ctrl};
          s_axi_rresp_o <= `XMI_RESP_OKAY;
        end
        `XMI_REG_STATUS: begin
          s_axi_rdata_o <= status_word;
          s_axi_rresp_o <= `XMI_RESP_OKAY;
        end
        default: begin
          s_axi_rdata_o <= 32'h00000000;
          s_axi_rresp_o <= `XMI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link timing: one 40 ns phase counter; the 50 MHz reference is every fourth cycle

  localparam integer LAST_PH = `XMI_LINK_PERIOD_CYC - 1;
  localparam integer HALF_PH = `XMI_LINK_PERIOD_CYC / 2;
  localparam integer SHIFT_PH = `XMI_SHIFT_CYC;
  localparam integer RMII_LAST = `XMI_RMII_PERIOD_CYC - 1;

  reg [2:0] ph;
  reg osc_prev;
  reg clk50;
  reg [1:0] clk_pin_q;
  wire osc_s;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph <= 3'h0;
    end else if (ph == LAST_PH[2:0]) begin
      ph <= 3'h0;
    end else begin
      ph <= ph + 3'h1;
    end
  end

  xmi_pin_sync #(.WIDTH(1)) u_osc_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pin_i(osc_in_pin_i),
    .level_o(osc_s)
  );

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_prev <= 1'b0;
      clk50 <= 1'b0;
      clk_pin_q <= `XMI_CLKSEL_NONE;
    end else begin
      osc_prev <= osc_s;
      clk50 <= ph[1];
      // the pin choice only moves while the reference is low, so the mac never sees a runt pulse
      if (ph[1:0] == 2'h1) begin
        clk_pin_q <= (is_rmii && rmii_master) ? clk_sel : `XMI_CLKSEL_NONE;
      end
    end
  end

  // slave follows the shared oscillator, master its own derived reference
  wire rmii_tick = is_rmii && (rmii_master ? (ph[1:0] == RMII_LAST[1:0]) : (osc_s && !osc_prev));
  wire l_lo = (is_mii || is_rgmii) && (ph == 3'h0);
  wire l_hi = is_rgmii && (ph == HALF_PH[2:0]);
  wire unit = l_lo || l_hi || rmii_tick;

  ////////////////////////////////////////////////////////////////////////////
  // receive path toward the mac

  reg [7:0] rx_sr;
  reg [1:0] rx_cnt;
  reg [3:0] rx_nib;
  reg rx_err_q;
  reg rx_act;
  wire [2:0] rx_rel = ph - (rx_shift ? SHIFT_PH[2:0] : 3'h0);

  // a byte starts only on a rising-edge slot, never mid-cycle
  assign rx_byte_ready_o = unit && !l_hi && (rx_cnt == 2'h0);
  assign rx_busy = rx_act;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sr <= 8'h00;
      rx_cnt <= 2'h0;
      rx_nib <= 4'h0;
      rx_err_q <= 1'b0;
      rx_act <= 1'b0;
      rx_ctrl_o <= 1'b0;
    end else if (unit) begin
      if (rx_byte_ready_o && rx_byte_valid_i) begin
        rx_act <= 1'b1;
        rx_err_q <= rx_byte_err_i;
        rx_ctrl_o <= 1'b1;
        if (is_rmii) begin
          rx_nib <= {2'h0, rx_byte_i[1:0]};
          rx_sr <= {2'h0, rx_byte_i[7:2]};
          rx_cnt <= 2'h3;
        end else begin
          rx_nib <= rx_byte_i[3:0];
          rx_sr <= {4'h0, rx_byte_i[7:4]};
          rx_cnt <= 2'h1;
        end
      end else if (rx_cnt != 2'h0) begin
        rx_cnt <= rx_cnt - 2'h1;
        if (is_rmii) begin
          rx_nib <= {2'h0, rx_sr[1:0]};
          rx_sr <= {2'h0, rx_sr[7:2]};
          rx_ctrl_o <= 1'b1;
        end else begin
          rx_nib <= rx_sr[3:0];
          rx_sr <= {4'h0, rx_sr[7:4]};
          // rgmii falling edge carries enable xor error
          rx_ctrl_o <= is_rgmii ? !rx_err_q : 1'b1;
        end
      end else begin
        rx_nib <= 4'h0;
        rx_act <= 1'b0;
        rx_err_q <= 1'b0;
        rx_ctrl_o <= 1'b0;
      end
    end
  end

  // rgmii align: clock edge with data; rgmii shift: edge a rounded-up 3.5 ns later; mii ignores the shift
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_clk_o <= 1'b0;
    end else if (is_rgmii) begin
      rx_clk_o <= !rx_rel[2];
    end else if (is_mii) begin
      rx_clk_o <= ph[2];
    end else begin
      rx_clk_o <= 1'b0;
    end
  end

  // rmii frees rx data bit 3, which then carries the reference out
  assign rx_d_o = {(clk_pin_q == `XMI_CLKSEL_GP3) ? clk50 : rx_nib[3], rx_nib[2:0]};
  assign general_purpose_pin_one_o = (clk_pin_q == `XMI_CLKSEL_GP1) && clk50;
  assign general_purpose_pin_two_o = (clk_pin_q == `XMI_CLKSEL_GP2) && clk50;

  ////////////////////////////////////////////////////////////////////////////
  // transmit path from the mac

  wire [5:0] tx_pins_s;
  reg tx_clk_prev;
  reg rise_d;
  reg fall_d;
  reg [7:0] tx_sr;
  reg [1:0] tx_cnt;
  reg tx_lo_en;

  xmi_pin_sync #(.WIDTH(6)) u_tx_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pin_i({tx_clk_i, tx_ctrl_i, tx_d_i}),
    .level_o(tx_pins_s)
  );

  wire tx_clk_s = tx_pins_s[5];
  wire tx_ctl_s = tx_pins_s[4];
  wire [3:0] tx_d_s = tx_pins_s[3:0];
  wire rise_now = tx_clk_s && !tx_clk_prev;
  wire fall_now = !tx_clk_s && tx_clk_prev;
  // with tx shift the mac launches on the edge, so sampling waits one delay
  wire tx_rise = tx_shift ? rise_d : rise_now;
  wire tx_fall = tx_shift ? fall_d : fall_now;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_clk_prev <= 1'b0;
      rise_d <= 1'b0;
      fall_d <= 1'b0;
    end else begin
      tx_clk_prev <= tx_clk_s;
      rise_d <= rise_now;
      fall_d <= fall_now;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_sr <= 8'h00;
      tx_cnt <= 2'h0;
      tx_lo_en <= 1'b0;
      tx_byte_o <= 8'h00;
      tx_byte_err_o <= 1'b0;
      tx_byte_valid_o <= 1'b0;
      tx_active_o <= 1'b0;
    end else begin
      tx_byte_valid_o <= 1'b0;
      tx_byte_err_o <= 1'b0;
      if (is_rgmii) begin
        if (tx_rise) begin
          tx_sr[3:0] <= tx_d_s;
          tx_lo_en <= tx_ctl_s;
          tx_active_o <= tx_ctl_s;
        end else if (tx_fall && tx_lo_en) begin
          tx_byte_o <= {tx_d_s, tx_sr[3:0]};
          tx_byte_err_o <= tx_ctl_s ^ tx_lo_en;
          tx_byte_valid_o <= 1'b1;
          tx_lo_en <= 1'b0;
        end
      end else if ((is_mii && tx_rise) || rmii_tick) begin
        // a frame that ends mid-byte drops the partial byte
        tx_active_o <= tx_ctl_s;
        if (!tx_ctl_s) begin
          tx_cnt <= 2'h0;
        end else if (is_mii) begin
          tx_sr <= {tx_d_s, tx_sr[7:4]};
          tx_cnt <= (tx_cnt == 2'h1) ? 2'h0 : 2'h1;
          if (tx_cnt == 2'h1) begin
            tx_byte_o <= {tx_d_s, tx_sr[7:4]};
            tx_byte_valid_o <= 1'b1;
          end
        end else begin
          tx_sr <= {tx_d_s[1:0], tx_sr[7:2]};
          tx_cnt <= tx_cnt + 2'h1;
          if (tx_cnt == 2'h3) begin
            tx_byte_o <= {tx_d_s[1:0], tx_sr[7:2]};
            tx_byte_valid_o <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mii line status

  assign crs_o = is_mii && (tx_active_o || rx_act);
  assign col_o = is_mii && !full_duplex && tx_active_o && rx_act;

endmodule

// ### tb/xmi_mac_if_assertions.sv
// concurrent checks on the ports of the mac-side xmii interface
`timescale 1ns/1ps
module xmi_mac_if_assertions (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // watched ports
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire crs_o,
  input wire col_o,
  input wire general_purpose_pin_one_o,
  input wire general_purpose_pin_two_o,
  input wire rx_byte_valid_i,
  input wire rx_byte_ready_o,
  input wire tx_byte_valid_o,
  input wire tx_active_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////
  chk_col_has_crs: assert property (col_o |-> crs_o)
    else $error("collision without carrier sense");
  chk_col_needs_tx: assert property (col_o |-> tx_active_o)
    else $error("collision while not transmitting");
  chk_tx_byte_pulse: assert property (tx_byte_valid_o |=> !tx_byte_valid_o)
    else $error("transmit byte strobe longer than one cycle");
  chk_rx_slot_pulse: assert property (rx_byte_ready_o |=> !rx_byte_ready_o)
    else $error("receive slot longer than one cycle");
  chk_rx_byte_gap: assert property (
    rx_byte_valid_i && rx_byte_ready_o |=> !rx_byte_ready_o [*7])
    else $error("next receive byte taken too early");
  chk_one_clock_pin: assert property (
    !($changed(general_purpose_pin_one_o) && $changed(general_purpose_pin_two_o)))
    else $error("two clock pins toggle together");
  chk_clk_out_rate: assert property (
    $rose(general_purpose_pin_one_o) |-> general_purpose_pin_one_o [*2] ##1 !general_purpose_pin_one_o)
    else $error("clock output half period not two cycles");
  chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
endmodule
bind xmi_mac_if xmi_mac_if_assertions xmi_mac_if_assertions_i (.clk_sys_i, .reset_n_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .crs_o, .col_o, .general_purpose_pin_one_o, .general_purpose_pin_two_o,
  .rx_byte_valid_i, .rx_byte_ready_o, .tx_byte_valid_o, .tx_active_o);

// ### tb/xmi_mac_model.sv
// behavioural mac transmitter driving the phy transmit pins
`timescale 1ns/1ps
`include "xmi_defs.vh"
module xmi_mac_model (
  // mac transmit pins
  output logic tx_clk_o,
  output logic [3:0] tx_d_o,
  output logic tx_ctrl_o
);
  initial begin
    tx_clk_o = 1'b0;
    tx_d_o = 4'h0;
    tx_ctrl_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // one 125 ns clock, data set 31.25 ns before the rising edge; the clock stands still between frames
  task automatic beat(input logic [3:0] d, input logic c);
    tx_d_o = d;
    tx_ctrl_o = c;
    #31.25 tx_clk_o = 1'b1;
    #62.5 tx_clk_o = 1'b0;
    #31.25;
  endtask
  // a trailing beat with enable low lets the phy see the frame end; idle data is inverted
  task automatic send(input logic [1:0] mode, input logic [7:0] b, input logic e);
    if (mode == `XMI_MODE_RGMII) begin
      tx_d_o = b[3:0];
      tx_ctrl_o = 1'b1;
      #31.25 tx_clk_o = 1'b1;
      #31.25 tx_d_o = b[7:4];
      tx_ctrl_o = ~e;
      #31.25 tx_clk_o = 1'b0;
      #31.25;
    end else begin
      beat(b[3:0], 1'b1);
      beat(b[7:4], 1'b1);
    end
    beat(~tx_d_o, 1'b0);
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the mac-side xmii interface
`timescale 1ns/1ps
`include "xmi_defs.vh"
module tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic rmii_master_strap_i = 1'b0;
  logic osc_in_pin_i = 1'b0;
  logic [3:0] s_axi_awaddr_i = 4'h0;
  logic [3:0] s_axi_araddr_i = 4'h0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0] rx_byte_i = 8'h0;
  logic rx_byte_err_i = 1'b0, rx_byte_valid_i = 1'b0;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire tx_clk_i, tx_ctrl_i, rx_clk_o, rx_ctrl_o, crs_o, col_o;
  wire [3:0] tx_d_i, rx_d_o;
  wire general_purpose_pin_one_o, general_purpose_pin_two_o, rx_byte_ready_o;
  wire [7:0] tx_byte_o;
  wire tx_byte_err_o, tx_byte_valid_o, tx_active_o;
  int err_count = 0, checked = 0, cyc = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  // free-running 50 MHz reference; its edges stay clear of the system clock rising edges
  always #10 osc_in_pin_i = ~osc_in_pin_i;
  xmi_mac_if xmi_mac_if_i (.clk_sys_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .rmii_master_strap_i, .osc_in_pin_i, .tx_clk_i, .tx_d_i,
    .tx_ctrl_i, .rx_clk_o, .rx_d_o, .rx_ctrl_o, .crs_o, .col_o, .general_purpose_pin_one_o,
    .general_purpose_pin_two_o, .rx_byte_i, .rx_byte_err_i, .rx_byte_valid_i, .rx_byte_ready_o,
    .tx_byte_o, .tx_byte_err_o, .tx_byte_valid_o, .tx_active_o);
  xmi_mac_model xmi_mac_model_i (.tx_clk_o(tx_clk_i), .tx_d_o(tx_d_i), .tx_ctrl_o(tx_ctrl_i));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    rmii_master_strap_i <= s;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    cmp(s_axi_bresp_o, r);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    cmp(s_axi_rdata_o, d);
    cmp(s_axi_rresp_o, r);
  endtask
  // returns at the edge on which the byte is taken
  task automatic rx_push(input logic [7:0] b, input logic e);
    @(posedge clk_sys_i);
    rx_byte_i <= b;
    rx_byte_err_i <= e;
    rx_byte_valid_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (rx_byte_ready_o !== 1'b1);
    rx_byte_valid_i <= 1'b0;
  endtask
  task automatic chk_pin(input int k, input logic [3:0] m, input logic [3:0] d, input logic c);
    repeat (k) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    cmp({rx_d_o & m, rx_ctrl_o}, {d, c});
  endtask
  // one byte out as four dibits, low pair first, one reference cycle apart
  task automatic rmii_rx(input logic [7:0] b);
    rx_push(b, 1'b0);
    for (int i = 0; i < 4; i++)
      chk_pin(i == 0 ? 0 : 4, 4'h3, 4'((b >> (2 * i)) & 8'h03), 1'b1);
  endtask
  task automatic wait_tx(input logic [8:0] exp);
    do begin
      @(posedge clk_sys_i);
    end while (tx_byte_valid_o !== 1'b1);
    cmp({tx_byte_err_o, tx_byte_o}, exp);
  endtask
  // counts rising edges of a clock output over 40 cycles
  task automatic rises(input logic sel, input int exp);
    int r = 0;
    logic p, q;
    @(negedge clk_sys_i);
    p = sel ? rx_d_o[3] : general_purpose_pin_one_o;
    repeat (40) begin
      @(negedge clk_sys_i);
      q = sel ? rx_d_o[3] : general_purpose_pin_one_o;
      if (q === 1'b1 && p === 1'b0) r++;
      p = q;
    end
    cmp(r, exp);
  endtask
  // mac transmits while a byte is received; collision only in half duplex
  task automatic mii_overlap(input logic ec);
    logic hit = 1'b0;
    fork
      xmi_mac_model_i.send(`XMI_MODE_MII, 8'h3C, 1'b0);
      wait_tx(9'h03C);
      begin
        repeat (20) @(posedge clk_sys_i);
        rx_push(8'hA5, 1'b0);
        chk_pin(0, 4'hF, 4'h5, 1'b1);
        cmp(crs_o, 1'b1);
        chk_pin(8, 4'hF, 4'hA, 1'b1);
      end
      repeat (120) begin
        @(negedge clk_sys_i);
        if (col_o === 1'b1 && crs_o === 1'b1) hit = 1'b1;
      end
    join
    cmp(hit, ec);
    repeat (30) @(posedge clk_sys_i);
    cmp({crs_o, col_o}, 2'b00);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  initial begin
    do_reset(1'b0);
    axi_rd(`XMI_REG_CTRL, 32'h04, `XMI_RESP_OKAY);
    axi_rd(`XMI_REG_STATUS, 32'h0, `XMI_RESP_OKAY);
    axi_rd(4'h8, 32'h0, `XMI_RESP_SLVERR);
    axi_wr(`XMI_REG_STATUS, 32'hFF, `XMI_RESP_SLVERR);
    $display("test registers done");
    mii_overlap(1'b1);
    axi_wr(`XMI_REG_CTRL, 32'h14, `XMI_RESP_OKAY);
    mii_overlap(1'b0);
    $display("test mii done");
    axi_wr(`XMI_REG_CTRL, 32'h06, `XMI_RESP_OKAY);
    rx_push(8'h96, 1'b1);
    chk_pin(0, 4'hF, 4'h6, 1'b1);
    cmp(rx_clk_o, 1'b0);
    chk_pin(1, 4'hF, 4'h6, 1'b1);
    cmp(rx_clk_o, 1'b1);
    chk_pin(3, 4'hF, 4'h9, 1'b0);
    axi_wr(`XMI_REG_CTRL, 32'h02, `XMI_RESP_OKAY);
    rx_push(8'h3E, 1'b0);
    chk_pin(0, 4'hF, 4'hE, 1'b1);
    cmp(rx_clk_o, 1'b1);
    chk_pin(4, 4'hF, 4'h3, 1'b1);
    fork
      xmi_mac_model_i.send(`XMI_MODE_RGMII, 8'h5A, 1'b1);
      wait_tx(9'h15A);
    join
    axi_wr(`XMI_REG_CTRL, 32'h0A, `XMI_RESP_OKAY);
    fork
      xmi_mac_model_i.send(`XMI_MODE_RGMII, 8'hC3, 1'b0);
      wait_tx(9'h0C3);
    join
    $display("test rgmii done");
    axi_wr(`XMI_REG_CTRL, 32'hA5, `XMI_RESP_OKAY);
    rmii_rx(8'hB4);
    rises(1'b0, 10);
    cmp(general_purpose_pin_two_o, 1'b0);
    // slave: the shared oscillator paces the dibits and no clock goes out
    axi_wr(`XMI_REG_CTRL, 32'h05, `XMI_RESP_OKAY);
    rmii_rx(8'h4B);
    cmp(general_purpose_pin_one_o, 1'b0);
    $display("test rmii done");
    do_reset(1'b1);
    axi_rd(`XMI_REG_CTRL, 32'hE5, `XMI_RESP_OKAY);
    axi_rd(`XMI_REG_STATUS, 32'h10, `XMI_RESP_OKAY);
    rises(1'b1, 10);
    $display("test strap done");
    wrap_up;
  end
endmodule
